// ### rsp_clk_pmu_ctrl.sv
// Clock gating, dividers, source select and power management control
//
// Function
// - link core clocks run only when enabled
// - low-power timer held reset while bit set
// - link core divider 1, 2, 4, 8
// - RF control unit clock gated by enable
// - RF control unit divider 1, 2, 4, 8
// - read-only flags show running clock source
// - spike filter bypassed while disable bit set
// - crystal off at once, stays off across sleep
// - selector picks crystal, RC or slow source
// - one retention bit per RAM macro
// - force boost or buck at next wakeup
// - boost wins when both are set
// - force bits lock after first write that sets either one
// - HCLK divider applied only during OTP mirroring
// - radio digital powered down while bit set
// - peripherals powered down while bit set
// - reset after wakeup when bit set
// - settled flag only after over 2 ms
`timescale 1ns/10ps
`default_nettype none

module rsp_clk_pmu_ctrl #(
   parameter int ADDR_W     = 32,
   parameter int SETTLE_CYC = rsp_pkg::SETTLE_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [15:0]       wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [15:0]       rdata,
   // Pins from the analog side
   input  wire logic [2:0]        src_active,
   input  wire logic              fast_crystal_trim_done,
   input  wire logic              sleep_active,
   // Same-clock status from the OTP controller
   input  wire logic              otp_mirror_active,
   // Radio clock outputs
   output logic                   link_core_tick,
   output logic                   link_lowpower_timer_rst,
   output logic                   rf_ctrl_unit_tick,
   // Oscillator and source outputs
   output logic [1:0]             sysclk_source_select,
   output logic                   fast_crystal_enable,
   output logic                   spike_filter_off,
   output logic                   fast_crystal_settled,
   // Power management outputs
   output logic [3:0]             retention_keep,
   output logic                   dcdc_boost,
   output logic                   dcdc_buck,
   output logic                   hclk_div_override,
   output logic [1:0]             hclk_div_value,
   output logic                   radio_powerdown,
   output logic                   peripheral_powerdown,
   output logic                   wake_reset_req
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (SETTLE_CYC < 2) begin : g_bad_settle
      $error("SETTLE_CYC must be at least 2");
   end
   if (ADDR_W < 32) begin : g_bad_addr
      $error("ADDR_W must hold the full register offsets");
   end

   // Low bits that must all be ones for a tick at a given divide setting
   // One free counter serves every ratio, so ticks stay evenly spaced
   function automatic logic [2:0] div_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    div_mask = 3'h0;
         2'h1:    div_mask = 3'h1;
         2'h2:    div_mask = 3'h3;
         2'h3:    div_mask = 3'h7;
         default: div_mask = 3'h0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   rsp_pkg::rsp_radio_s radio;
   rsp_pkg::rsp_sys_s   sys;
   rsp_pkg::rsp_pmu_s   pmu;
   logic                force_lock;
   logic [2:0]          src_flag;
   logic                trim_flag;
   logic                sleep_flag;

   logic hit_radio;
   logic hit_sys;
   logic hit_pmu;
   logic hit_stat;

   // Address decode against the full offsets; partial decode would alias
   // Stray writes to neighbouring words must not land here
   assign hit_radio = (addr == ADDR_W'(rsp_pkg::RADIO_CLK_OFS));
   assign hit_sys   = (addr == ADDR_W'(rsp_pkg::SYS_CLK_OFS));
   assign hit_pmu   = (addr == ADDR_W'(rsp_pkg::PMU_CTL_OFS));
   assign hit_stat  = (addr == ADDR_W'(rsp_pkg::CLK_STAT_OFS));

   // Radio clock control writes
   // Reserved bits are dropped and read back as zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         radio                         <= '0;
         radio.link_lowpower_timer_rst <= rsp_pkg::LP_RST_RST;
      end else if (wr && hit_radio) begin
         radio.link_core_clock_en      <= wdata[rsp_pkg::LINK_EN_BIT];
         radio.link_lowpower_timer_rst <= wdata[rsp_pkg::LP_RST_BIT];
         radio.link_core_clock_div     <= wdata[rsp_pkg::LINK_DIV_LSB +: 2];
         radio.rf_ctrl_unit_clock_en   <= wdata[rsp_pkg::RFCU_EN_BIT];
         radio.rf_ctrl_unit_clock_div  <= wdata[rsp_pkg::RFU_DIV_LSB +: 2];
      end
   end

   // System clock control writes; crystal disable takes effect next edge
   // Running flags are not stored here; they come from the pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sys <= '0;
      end else if (wr && hit_sys) begin
         sys.spike_filter_off     <= wdata[rsp_pkg::SPIKE_BIT];
         sys.fast_crystal_off     <= wdata[rsp_pkg::XTAL_OFF_BIT];
         sys.sysclk_source_select <= wdata[rsp_pkg::SRC_SEL_LSB +: 2];
      end
   end

   // Power management writes; force bits frozen once one was written as 1
   // Writing zeros to both force bits leaves them open
   // Only reset reopens the lock, so software gets one try
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pmu                      <= '0;
         pmu.radio_sleep          <= rsp_pkg::RADIO_PD_RST;
         pmu.peripheral_powerdown <= rsp_pkg::PERIPH_PD_RST;
         force_lock               <= 1'b0;
      end else if (wr && hit_pmu) begin
         pmu.retain               <= wdata[rsp_pkg::RET_LSB +: 4];
         pmu.otp_copy_div         <= wdata[rsp_pkg::OTP_DIV_LSB +: 2];
         pmu.radio_sleep          <= wdata[rsp_pkg::RADIO_PD_BIT];
         pmu.peripheral_powerdown <= wdata[rsp_pkg::PERIPH_PD_BIT];
         pmu.reset_on_wake        <= wdata[rsp_pkg::WAKE_RST_BIT];
         if (!force_lock) begin
            pmu.force_boost <= wdata[rsp_pkg::BOOST_BIT];
            pmu.force_buck  <= wdata[rsp_pkg::BUCK_BIT];
            force_lock      <= wdata[rsp_pkg::BOOST_BIT] |
                               wdata[rsp_pkg::BUCK_BIT];
         end
      end
   end

   // Read data valid only in the cycle after the strobe
   // Zero outside that cycle, and for unmapped addresses, so a
   // shared read mux can simply OR the slaves together
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= '0;
         if (rd && hit_radio) begin
            rdata[rsp_pkg::LINK_EN_BIT]         <= radio.link_core_clock_en;
            rdata[rsp_pkg::LP_RST_BIT]          <= radio.link_lowpower_timer_rst;
            rdata[rsp_pkg::LINK_DIV_LSB +: 2]   <= radio.link_core_clock_div;
            rdata[rsp_pkg::RFCU_EN_BIT]         <= radio.rf_ctrl_unit_clock_en;
            rdata[rsp_pkg::RFU_DIV_LSB +: 2]    <= radio.rf_ctrl_unit_clock_div;
         end else if (rd && hit_sys) begin
            rdata[rsp_pkg::ON_XTAL_BIT]         <= src_flag[2];
            rdata[rsp_pkg::ON_RC_BIT]           <= src_flag[1];
            rdata[rsp_pkg::ON_SLOW_BIT]         <= src_flag[0];
            rdata[rsp_pkg::SPIKE_BIT]           <= sys.spike_filter_off;
            rdata[rsp_pkg::XTAL_OFF_BIT]        <= sys.fast_crystal_off;
            rdata[rsp_pkg::SRC_SEL_LSB +: 2]    <= sys.sysclk_source_select;
         end else if (rd && hit_pmu) begin
            rdata[rsp_pkg::RET_LSB +: 4]        <= pmu.retain;
            rdata[rsp_pkg::BOOST_BIT]           <= pmu.force_boost;
            rdata[rsp_pkg::BUCK_BIT]            <= pmu.force_buck;
            rdata[rsp_pkg::OTP_DIV_LSB +: 2]    <= pmu.otp_copy_div;
            rdata[rsp_pkg::RADIO_PD_BIT]        <= pmu.radio_sleep;
            rdata[rsp_pkg::PERIPH_PD_BIT]       <= pmu.peripheral_powerdown;
            rdata[rsp_pkg::WAKE_RST_BIT]        <= pmu.reset_on_wake;
         end else if (rd && hit_stat) begin
            rdata[rsp_pkg::SETTLED_BIT]         <= fast_crystal_settled;
            rdata[rsp_pkg::TRIM_BIT]            <= trim_flag;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Bit 4 sleep, bit 3 trim done, bits 2:0 active source (crystal, RC, slow)
   localparam logic [4:0] PIN_RST = {1'b0, 1'b0, rsp_pkg::SRC_FLAG_RST};

   logic [4:0] pin_raw;
   logic [4:0] pin_s1;
   logic [4:0] pin_s2;
   logic [4:0] pin_s3;
   logic [4:0] pin_ok;

   assign pin_raw = {sleep_active, fast_crystal_trim_done, src_active};

   // Three stages; a value is taken only when stages two and three agree
   // A pin caught mid-change is held off until both stages settle,
   // at the cost of one extra cycle of latency
   for (genvar i = 0; i < 5; i++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            pin_s1[i] <= PIN_RST[i];
            pin_s2[i] <= PIN_RST[i];
            pin_s3[i] <= PIN_RST[i];
            pin_ok[i] <= PIN_RST[i];
         end else begin
            pin_s1[i] <= pin_raw[i];
            pin_s2[i] <= pin_s1[i];
            pin_s3[i] <= pin_s2[i];
            if (pin_s2[i] == pin_s3[i]) begin
               pin_ok[i] <= pin_s3[i];
            end
         end
      end
   end

   // Flags follow the mux's own report, not the requested code,
   // so a requested source only shows once it really drives the clock
   assign src_flag   = pin_ok[2:0];
   assign trim_flag  = pin_ok[3];
   assign sleep_flag = pin_ok[4];

   ////////////////////////////////////////////////////////////////////////////
   // Clock dividers

   logic [2:0] link_cnt;
   logic [2:0] rfcu_cnt;
   logic [1:0] link_div_act;
   logic [1:0] rfu_div_act;

   // New divide settings load only at the counter wrap, so no short pulse
   // Worst case a new ratio waits eight cycles to take effect
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_cnt     <= '0;
         link_div_act <= '0;
      end else begin
         link_cnt <= link_cnt + 3'h1;
         if (link_cnt == 3'h7) begin
            link_div_act <= radio.link_core_clock_div;
         end
      end
   end

   // Same scheme for the RF control unit; counters run even when gated
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rfcu_cnt     <= '0;
         rfu_div_act  <= '0;
      end else begin
         rfcu_cnt <= rfcu_cnt + 3'h1;
         if (rfcu_cnt == 3'h7) begin
            rfu_div_act <= radio.rf_ctrl_unit_clock_div;
         end
      end
   end

   // Gated, divided tick enables for the two radio clock domains
   // Registered, so a divider load can never glitch a tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_core_tick    <= 1'b0;
         rf_ctrl_unit_tick <= 1'b0;
      end else begin
         link_core_tick    <= radio.link_core_clock_en &
            ((link_cnt & div_mask(link_div_act)) == div_mask(link_div_act));
         rf_ctrl_unit_tick <= radio.rf_ctrl_unit_clock_en &
            ((rfcu_cnt & div_mask(rfu_div_act)) == div_mask(rfu_div_act));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator and source control

   logic [$clog2(SETTLE_CYC+2)-1:0] settle_cnt;

   // Crystal runs only when not disabled and the chip is awake
   // The off bit outlives sleep, so a wakeup does not restart it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fast_crystal_enable  <= 1'b1;
         spike_filter_off     <= 1'b0;
         sysclk_source_select <= rsp_pkg::SEL_XTAL;
      end else begin
         fast_crystal_enable  <= ~sys.fast_crystal_off & ~sleep_flag;
         spike_filter_off     <= sys.spike_filter_off;
         sysclk_source_select <= sys.sysclk_source_select;
      end
   end

   // Settle timer restarts whenever the crystal is stopped
   // Counts one past the limit so settled means strictly more than it;
   // even a one-cycle stop costs a full settle time
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         settle_cnt           <= '0;
         fast_crystal_settled <= 1'b0;
      end else if (!fast_crystal_enable) begin
         settle_cnt           <= '0;
         fast_crystal_settled <= 1'b0;
      end else if (settle_cnt <= ($bits(settle_cnt))'(SETTLE_CYC)) begin
         settle_cnt <= settle_cnt + 1'b1;
      end else begin
         fast_crystal_settled <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power management

   logic sleep_q;
   logic wake_evt;

   assign wake_evt = sleep_q & ~sleep_flag;

   // Converter mode and reset request latched on the wakeup edge
   // Modes never change while awake; the reset request is one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleep_q        <= 1'b0;
         dcdc_boost     <= 1'b0;
         dcdc_buck      <= 1'b0;
         wake_reset_req <= 1'b0;
      end else begin
         sleep_q        <= sleep_flag;
         wake_reset_req <= wake_evt & pmu.reset_on_wake;
         if (wake_evt) begin
            dcdc_boost <= pmu.force_boost;
            dcdc_buck  <= pmu.force_buck & ~pmu.force_boost;
         end
      end
   end

   // Static power controls straight from the register
   // Outside mirroring the override value is held at divide by one
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         link_lowpower_timer_rst <= rsp_pkg::LP_RST_RST;
         retention_keep          <= '0;
         radio_powerdown         <= rsp_pkg::RADIO_PD_RST;
         peripheral_powerdown    <= rsp_pkg::PERIPH_PD_RST;
         hclk_div_override       <= 1'b0;
         hclk_div_value          <= '0;
      end else begin
         link_lowpower_timer_rst <= radio.link_lowpower_timer_rst;
         retention_keep          <= pmu.retain;
         radio_powerdown         <= pmu.radio_sleep;
         peripheral_powerdown    <= pmu.peripheral_powerdown;
         hclk_div_override       <= otp_mirror_active;
         hclk_div_value          <= otp_mirror_active ? pmu.otp_copy_div : 2'h0;
      end
   end

endmodule

`default_nettype wire

// ### rsp_pkg.sv
// Shared register map, field layout, reset values and timing for the clock/power control block
`default_nettype none

package rsp_pkg;

   // Register offsets; the status word is a local addition
   localparam logic [31:0] RADIO_CLK_OFS = 32'h5000_0008;
   localparam logic [31:0] SYS_CLK_OFS   = 32'h5000_000a;
   localparam logic [31:0] PMU_CTL_OFS   = 32'h5000_0010;
   localparam logic [31:0] CLK_STAT_OFS  = 32'h5000_0040;

   // Radio clock control fields
   localparam int LINK_EN_BIT  = 7;
   localparam int LP_RST_BIT   = 6;
   localparam int LINK_DIV_LSB = 4;
   localparam int RFCU_EN_BIT  = 3;
   localparam int RFU_DIV_LSB  = 0;

   // System clock control fields
   localparam int ON_XTAL_BIT  = 7;
   localparam int ON_RC_BIT    = 6;
   localparam int ON_SLOW_BIT  = 5;
   localparam int SPIKE_BIT    = 3;
   localparam int XTAL_OFF_BIT = 2;
   localparam int SRC_SEL_LSB  = 0;

   // Power management fields
   localparam int RET_LSB      = 8;
   localparam int BOOST_BIT    = 7;
   localparam int BUCK_BIT     = 6;
   localparam int OTP_DIV_LSB  = 4;
   localparam int RADIO_PD_BIT = 2;
   localparam int PERIPH_PD_BIT = 1;
   localparam int WAKE_RST_BIT = 0;

   // Status fields
   localparam int SETTLED_BIT  = 1;
   localparam int TRIM_BIT     = 0;

   // Reset values of the stored fields
   localparam logic       LP_RST_RST    = 1'h1;
   localparam logic       RADIO_PD_RST  = 1'h1;
   localparam logic       PERIPH_PD_RST = 1'h1;
   localparam logic [2:0] SRC_FLAG_RST  = 3'h4;

   // Source selector codes; 2 and 3 both mean a slow source
   localparam logic [1:0] SEL_XTAL = 2'h0;
   localparam logic [1:0] SEL_RC   = 2'h1;

   // Crystal settle time and its cycle count at the core clock rate
   localparam int CLK_KHZ       = 20000;
   localparam int SETTLE_TIME_US = 2000;
   localparam int SETTLE_CYC    = SETTLE_TIME_US * CLK_KHZ / 1000;

   typedef struct packed {
      logic       link_core_clock_en;
      logic       link_lowpower_timer_rst;
      logic [1:0] link_core_clock_div;
      logic       rf_ctrl_unit_clock_en;
      logic [1:0] rf_ctrl_unit_clock_div;
   } rsp_radio_s;

   typedef struct packed {
      logic       spike_filter_off;
      logic       fast_crystal_off;
      logic [1:0] sysclk_source_select;
   } rsp_sys_s;

   typedef struct packed {
      logic [3:0] retain;
      logic       force_boost;
      logic       force_buck;
      logic [1:0] otp_copy_div;
      logic       radio_sleep;
      logic       peripheral_powerdown;
      logic       reset_on_wake;
   } rsp_pmu_s;

endpackage

`default_nettype wire

// ### rsp_clk_pmu_ctrl_asserts.sv
// Port checks for the clock and power control block
`timescale 1ns/10ps
`default_nettype none

module rsp_clk_pmu_ctrl_asserts #(
   parameter int ADDR_W     = 32,
   parameter int SETTLE_CYC = 20
) (
   // Clock, reset and inputs
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [15:0]       wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic              otp_mirror_active,
   // Outputs watched
   input wire logic [15:0]       rdata,
   input wire logic              link_core_tick,
   input wire logic              link_lowpower_timer_rst,
   input wire logic [1:0]        sysclk_source_select,
   input wire logic              fast_crystal_enable,
   input wire logic              spike_filter_off,
   input wire logic              fast_crystal_settled,
   input wire logic [3:0]        retention_keep,
   input wire logic              dcdc_boost,
   input wire logic              dcdc_buck,
   input wire logic              hclk_div_override,
   input wire logic [1:0]        hclk_div_value,
   input wire logic              radio_powerdown,
   input wire logic              peripheral_powerdown,
   input wire logic              wake_reset_req
);
   logic w_ra;
   logic w_sy;
   logic w_pm;
   int   on_cnt;

   // Write strobes decoded per register
   assign w_ra = wr && (addr == ADDR_W'(rsp_pkg::RADIO_CLK_OFS));
   assign w_sy = wr && (addr == ADDR_W'(rsp_pkg::SYS_CLK_OFS));
   assign w_pm = wr && (addr == ADDR_W'(rsp_pkg::PMU_CTL_OFS));

   // Crystal on-time, saturating so it never wraps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         on_cnt <= 0;
      end else if (!fast_crystal_enable) begin
         on_cnt <= 0;
      end else if (on_cnt < SETTLE_CYC + 8) begin
         on_cnt <= on_cnt + 1;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_rd_data_idle:
      assert property (!$past(rd) |-> rdata == 16'h0000) else $error("rdata not idle");
   a_link_gate_off:
      assert property (w_ra && !wdata[7] |-> ##2 !link_core_tick) else $error("link tick off");
   a_lp_timer_rst:
      assert property (w_ra |-> ##2 link_lowpower_timer_rst == $past(wdata[6], 2))
      else $error("lp reset wrong");
   a_sys_sel_copy:
      assert property (w_sy |-> ##2 {spike_filter_off, sysclk_source_select}
                       == {$past(wdata[3], 2), $past(wdata[1:0], 2)}) else $error("sys sel wrong");
   a_xtal_stop:
      assert property (w_sy && wdata[2] |-> ##2 !fast_crystal_enable) else $error("xtal on");
   a_pmu_levels:
      assert property (w_pm |-> ##2 {retention_keep, radio_powerdown, peripheral_powerdown}
                       == {$past(wdata[11:8], 2), $past(wdata[2:1], 2)}) else $error("pmu wrong");
   a_boost_wins:
      assert property (!(dcdc_boost && dcdc_buck)) else $error("boost and buck");
   a_wake_pulse:
      assert property (wake_reset_req |=> !wake_reset_req) else $error("wake pulse long");
   a_otp_override:
      assert property ($rose(otp_mirror_active) |-> ##[1:2] hclk_div_override)
      else $error("no override");
   a_otp_idle_div:
      assert property (!hclk_div_override |-> hclk_div_value == 2'h0) else $error("div leak");
   a_settle_time:
      assert property ($rose(fast_crystal_settled) |-> on_cnt >= SETTLE_CYC)
      else $error("settled early");
endmodule

bind rsp_clk_pmu_ctrl rsp_clk_pmu_ctrl_asserts #(.ADDR_W(ADDR_W), .SETTLE_CYC(SETTLE_CYC)) u_chk (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .otp_mirror_active(otp_mirror_active), .link_core_tick(link_core_tick),
   .link_lowpower_timer_rst(link_lowpower_timer_rst), .sysclk_source_select(sysclk_source_select),
   .fast_crystal_enable(fast_crystal_enable), .spike_filter_off(spike_filter_off),
   .fast_crystal_settled(fast_crystal_settled), .retention_keep(retention_keep),
   .dcdc_boost(dcdc_boost), .dcdc_buck(dcdc_buck), .hclk_div_override(hclk_div_override),
   .hclk_div_value(hclk_div_value), .radio_powerdown(radio_powerdown),
   .peripheral_powerdown(peripheral_powerdown), .wake_reset_req(wake_reset_req));

`default_nettype wire

// ### rsp_clk_pmu_ctrl_tb.sv
// Self-checking bench for the clock and power control block
`timescale 1ns/10ps
`default_nettype none

module rsp_clk_pmu_ctrl_tb;
   localparam int SET = 20;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] addr = 32'h0;
   logic [15:0] wdata = 16'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [2:0]  src = 3'h4;
   logic        trim = 1'b0;
   logic        slp = 1'b0;
   logic        otp = 1'b0;
   logic [15:0] rdata;
   logic        lt, lpr, rt, xen, spk, stl, bst, bck, hov, rpd, ppd, wrq;
   logic [1:0]  sel, hdv;
   logic [3:0]  ret;
   int          mismatches = 0;
   int          checks_done = 0;

   // Short settle count keeps the run brief
   rsp_clk_pmu_ctrl #(.ADDR_W(32), .SETTLE_CYC(SET)) dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .src_active(src), .fast_crystal_trim_done(trim), .sleep_active(slp),
      .otp_mirror_active(otp), .link_core_tick(lt), .link_lowpower_timer_rst(lpr),
      .rf_ctrl_unit_tick(rt), .sysclk_source_select(sel), .fast_crystal_enable(xen),
      .spike_filter_off(spk), .fast_crystal_settled(stl), .retention_keep(ret),
      .dcdc_boost(bst), .dcdc_buck(bck), .hclk_div_override(hov), .hclk_div_value(hdv),
      .radio_powerdown(rpd), .peripheral_powerdown(ppd), .wake_reset_req(wrq));

   // 20 MHz clock
   always #25 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic expire(input string what);
      mismatches++;
      $display("BAD %0t timeout %s", $time, what);
      test_done();
   endtask

   task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [31:0] a, input logic [15:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic cnt_ticks(output int nl, output int nr);
      nl = 0;
      nr = 0;
      repeat (64) begin
         settle(1);
         nl += int'(lt === 1'b1);
         nr += int'(rt === 1'b1);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(16'({lpr, rpd, ppd, xen}), 16'h000f);
      chk(16'({lt, rt, bst, bck, wrq}), 16'h0000);
      rd_chk(rsp_pkg::RADIO_CLK_OFS, 16'h0040);
      rd_chk(rsp_pkg::SYS_CLK_OFS, 16'h0080);
      rd_chk(rsp_pkg::PMU_CTL_OFS, 16'h0006);
      rd_chk(32'h5000_000c, 16'h0000);
      $display("reset test done");
   endtask

   // Every divider code on both radio clocks, then gated off
   task automatic t_radio;
      int nl;
      int nr;
      for (int d = 0; d < 4; d++) begin
         wr_reg(rsp_pkg::RADIO_CLK_OFS, 16'h0088 | 16'(d << 4) | 16'(d));
         settle(16);
         cnt_ticks(nl, nr);
         chk(16'(nl), 16'(64 >> d));
         chk(16'(nr), 16'(64 >> d));
         chk(16'(lpr), 16'h0000);
      end
      wr_reg(rsp_pkg::RADIO_CLK_OFS, 16'h0040);
      settle(4);
      cnt_ticks(nl, nr);
      chk(16'(nl + nr), 16'h0000);
      chk(16'(lpr), 16'h0001);
      $display("radio clock test done");
   endtask

   // Selector codes, running flags from the pins, crystal stop
   task automatic t_sys;
      for (int v = 0; v < 4; v++) begin
         wr_reg(rsp_pkg::SYS_CLK_OFS, 16'(v | 8));
         settle(3);
         chk(16'({spk, sel}), 16'(v | 4));
         rd_chk(rsp_pkg::SYS_CLK_OFS, 16'h0088 | 16'(v));
      end
      @(posedge clk);
      src <= 3'h1;
      settle(5);
      rd_chk(rsp_pkg::SYS_CLK_OFS, 16'h002b);
      wr_reg(rsp_pkg::SYS_CLK_OFS, 16'h0001);
      src <= 3'h2;
      settle(5);
      rd_chk(rsp_pkg::SYS_CLK_OFS, 16'h0041);
      wr_reg(rsp_pkg::SYS_CLK_OFS, 16'h0005);
      settle(3);
      chk(16'(xen), 16'h0000);
      $display("system clock test done");
   endtask

   // Both force bits, lock, mirroring divider, sleep and wakeup
   task automatic t_pmu;
      int n;
      wr_reg(rsp_pkg::PMU_CTL_OFS, 16'h0fe1);
      settle(3);
      chk(16'({ret, rpd, ppd, bst, bck}), 16'h00f0);
      wr_reg(rsp_pkg::PMU_CTL_OFS, 16'h0023);
      rd_chk(rsp_pkg::PMU_CTL_OFS, 16'h00e3);
      chk(16'({ret, ppd}), 16'h0001);
      @(posedge clk);
      otp <= 1'b1;
      settle(3);
      chk(16'({hov, hdv}), 16'h0006);
      @(posedge clk);
      otp <= 1'b0;
      settle(3);
      chk(16'({hov, hdv}), 16'h0000);
      @(posedge clk);
      slp <= 1'b1;
      settle(8);
      chk(16'(xen), 16'h0000);
      @(posedge clk);
      slp <= 1'b0;
      for (n = 0; n < 12 && wrq !== 1'b1; n++) settle(1);
      if (wrq !== 1'b1) expire("wakeup");
      chk(16'({bst, bck}), 16'h0002);
      settle(4);
      chk(16'({xen, wrq}), 16'h0000);
      $display("power management test done");
   endtask

   // Crystal restart, settle time, then switch onto it
   task automatic t_settle;
      int n;
      chk(16'(stl), 16'h0000);
      @(posedge clk);
      trim <= 1'b1;
      wr_reg(rsp_pkg::SYS_CLK_OFS, 16'h0001);
      for (n = 0; n < SET + 12 && stl !== 1'b1; n++) settle(1);
      if (stl !== 1'b1) expire("settle");
      chk(16'(n >= SET && n <= SET + 8), 16'h0001);
      rd_chk(rsp_pkg::CLK_STAT_OFS, 16'h0003);
      wr_reg(rsp_pkg::SYS_CLK_OFS, 16'h0000);
      src <= 3'h4;
      settle(5);
      rd_chk(rsp_pkg::SYS_CLK_OFS, 16'h0080);
      $display("crystal settle test done");
   endtask

   // Reset, then every scenario in turn
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      settle(5);
      t_reset();
      t_radio();
      t_sys();
      t_pmu();
      t_settle();
      test_done();
   end
endmodule

`default_nettype wire
